// ===== src/mqiu_pkg.sv
// Package: register map, field layout and carrier types of the queue interrupt unit
package mqiu_pkg;

    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_ENABLE = 6'h00;
    localparam logic [5:0] IDX_STATUS = 6'h02;

    // Bus widths
    localparam int ADR_W = 8;
    localparam int DAT_W = 32;
    localparam int REG_W = 16;

    // Bit positions shared by the enable and status registers
    localparam int BIT_LINK = 15;
    localparam int BIT_TX_DONE = 14;
    localparam int BIT_RX_DONE = 13;
    localparam int BIT_TX_UNDERRUN = 12;
    localparam int BIT_RX_OVERRUN = 11;
    localparam int BIT_EARLY_RX = 10;
    localparam int BIT_TX_STOPPED = 9;
    localparam int BIT_RX_STOPPED = 8;
    localparam int BIT_RX_ERROR = 7;

    // Implemented bits; bits 6..0 are reserved and read zero
    localparam logic [15:0] IMPL_MASK = 16'hff80;

    // Reset values
    localparam logic [15:0] ENABLE_RESET = 16'h0000;
    localparam logic [15:0] STATUS_RESET = 16'h0000;

    // Event levels from the queue manager and MAC, one bit per source
    typedef struct packed {
        logic tx_done;
        logic rx_done;
        logic tx_underrun;
        logic rx_overrun;
        logic early_rx;
        logic tx_stopped;
        logic rx_stopped;
        logic rx_error_frame;
    } mqiu_events_t;

endpackage

// ===== src/mqiu_top.sv
// Interrupt enable and status unit for a single-port MAC with queue manager
//
// Summary of operation
// [R1] Enable bit 15 gates link change
// [R2] Enable bit 14 gates transmit done
// [R3] Enable bit 13 gates receive done
// [R4] Enable bit 12 gates transmit underrun
// [R5] Enable bit 11 gates receive overrun
// [R6] Enable bit 10 gates early receive
// [R7] Enable bit 9 gates transmit stopped
// [R8] Enable bit 8 gates receive stopped
// [R9] Enable bit 7 gates receive error frame
// [R10] Enables reset zero; bits 6..0 reserved
// [R11] Interrupt when any enabled status set
// [R12] Reading status never clears it
// [R13] Writing one clears; zeros ignored
// [R14] Bit 15 latches every link transition; blips under one clock may be missed
// [R15] Bit 14 latches on transmit done
// [R16] Bit 13 latches on frame received
// [R17] Bit 12 latches on transmit underrun
// [R18] Bit 11 latches on receive overrun
// [R19] Bit 10 latches on early receive
// [R20] Bits 9, 8 latch on process stop
// [R21] Bit 7 latches on receive error frame
// [R22] Status resets zero, latches regardless of enable
// [R23] Event beats clear in same cycle
`timescale 1ns/100ps

module mqiu_top (
    // Clock and synchronous reset
    input wire logic mclk,
    input wire logic reset,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [mqiu_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [mqiu_pkg::DAT_W-1:0] wb_dat_i,
    output logic [mqiu_pkg::DAT_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    // Event sources, same clock
    input wire mqiu_pkg::mqiu_events_t events,
    // Link state from the PHY pin, asynchronous
    input wire logic link_up,
    // Interrupt to the host, active high
    output logic irq
);

    // Register state
    logic [15:0] interrupt_enable; // Software gates
    logic [15:0] interrupt_status; // Sticky pending flags

    // Link synchroniser and edge history
    logic link_meta; // First stage, read only by link_sync
    logic link_sync; // Second stage, safe to use
    logic link_prev; // Previous synchronised level

    // Event history for rising-edge detection
    // A source held high counts once; it must fall to count again
    mqiu_pkg::mqiu_events_t events_prev;

    // Bus decode
    logic bus_req; // New access this cycle
    logic bus_wr; // New write access
    logic hit_enable; // Address selects enable
    logic hit_status; // Address selects status
    logic [15:0] lane_bits; // Bits covered by byte enables

    // Next values
    logic [15:0] set_vec; // Hardware set requests
    logic [15:0] clr_vec; // Software clear requests
    logic [15:0] next_enable;
    logic [15:0] next_status;
    logic next_irq;

    // Expand the low two byte enables into a bit mask
    function automatic logic [15:0] lane_mask(input logic [3:0] sel);
        lane_mask = {{8{sel[1]}}, {8{sel[0]}}};
    endfunction

    // Word index from a byte address
    function automatic logic [5:0] word_index(input logic [7:0] adr);
        word_index = adr[7:2];
    endfunction

    // Place one-cycle event pulses at their status positions
    function automatic logic [15:0] place_events(
        input logic link_edge,
        input mqiu_pkg::mqiu_events_t rise
    );
        logic [15:0] v;
        v = 16'h0000;
        v[mqiu_pkg::BIT_LINK] = link_edge;
        v[mqiu_pkg::BIT_TX_DONE] = rise.tx_done;
        v[mqiu_pkg::BIT_RX_DONE] = rise.rx_done;
        v[mqiu_pkg::BIT_TX_UNDERRUN] = rise.tx_underrun;
        v[mqiu_pkg::BIT_RX_OVERRUN] = rise.rx_overrun;
        v[mqiu_pkg::BIT_EARLY_RX] = rise.early_rx;
        v[mqiu_pkg::BIT_TX_STOPPED] = rise.tx_stopped;
        v[mqiu_pkg::BIT_RX_STOPPED] = rise.rx_stopped;
        v[mqiu_pkg::BIT_RX_ERROR] = rise.rx_error_frame;
        place_events = v;
    endfunction

    // Link pin crosses two flops before anything looks at it
    // Limitation: a link blip shorter than one clock may go unseen
    always_ff @(posedge mclk) begin
        if (reset) begin
            link_meta <= 1'b0;
            link_sync <= 1'b0;
        end else begin
            link_meta <= link_up;
            link_sync <= link_meta;
        end
    end

    // Edge history; link starts down, so a link already up
    // after reset reports one change, which is a real transition
    always_ff @(posedge mclk) begin
        if (reset) begin
            link_prev <= 1'b0;
            events_prev <= '0;
        end else begin
            link_prev <= link_sync;
            events_prev <= events;
        end
    end

    // Decode: one access per request, ack blocks a repeat
    // A master that keeps its strobe up past ack is taken again
    // one cycle later, as a fresh access
    always_comb begin
        bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
        bus_wr = bus_req & wb_we_i;
        hit_enable = (word_index(wb_adr_i) == mqiu_pkg::IDX_ENABLE);
        hit_status = (word_index(wb_adr_i) == mqiu_pkg::IDX_STATUS);
        lane_bits = lane_mask(wb_sel_i);
    end

    // Both link directions count, the others on rising edge only;
    // level sources held high raise a flag once, not every cycle
    always_comb begin
        set_vec = place_events(link_sync ^ link_prev, // [R14]
            events & ~events_prev); // [R15] [R16] [R17] [R18] [R19] [R20] [R21]
    end

    // Write-one-to-clear on selected lanes; zeros leave bits alone
    // Lanes 3 and 2 carry no bits, so their strobes change nothing
    always_comb begin
        if (bus_wr && hit_status) begin
            clr_vec = wb_dat_i[15:0] & lane_bits & mqiu_pkg::IMPL_MASK; // [R13]
        end else begin
            clr_vec = 16'h0000;
        end
    end

    // Enable register: byte-lane write, reserved bits forced low
    always_comb begin
        next_enable = interrupt_enable;
        if (bus_wr && hit_enable) begin
            next_enable = (interrupt_enable & ~lane_bits)
                | (wb_dat_i[15:0] & lane_bits);
        end
        next_enable = next_enable & mqiu_pkg::IMPL_MASK; // [R10]
    end

    // Status: set beats clear so no event is lost; enables play
    // no part here, a masked source still records its event
    always_comb begin
        next_status = (interrupt_status & ~clr_vec) | set_vec; // [R23] [R22]
        next_status = next_status & mqiu_pkg::IMPL_MASK;
    end

    // Interrupt computed from next values so the pin tracks the
    // registers in the same cycle, yet still leaves a flop
    // Trade-off: a deeper path into the flop, but no cycle of lag
    always_comb begin
        next_irq = |(next_status & next_enable); // [R11] [R1] [R2] [R3] [R4] [R5] [R6] [R7] [R8] [R9]
    end

    // Enable register
    always_ff @(posedge mclk) begin
        if (reset) begin
            interrupt_enable <= mqiu_pkg::ENABLE_RESET; // [R10]
        end else begin
            interrupt_enable <= next_enable;
        end
    end

    // Status register; a read never reaches clr_vec
    always_ff @(posedge mclk) begin
        if (reset) begin
            interrupt_status <= mqiu_pkg::STATUS_RESET; // [R22]
        end else begin
            interrupt_status <= next_status; // [R12]
        end
    end

    // Interrupt output
    always_ff @(posedge mclk) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= next_irq; // [R11]
        end
    end

    // Bus answer: ack one cycle after the request, then drop;
    // unmapped addresses ack with zero so the master never hangs
    // Read data is captured at the taking edge, so a flag that sets
    // while ack is up shows on the next read, not this one
    always_ff @(posedge mclk) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= bus_req;
            if (bus_req && !wb_we_i && hit_enable) begin
                wb_dat_o <= {16'h0000, interrupt_enable};
            end else if (bus_req && !wb_we_i && hit_status) begin
                wb_dat_o <= {16'h0000, interrupt_status};
            end else if (bus_req) begin
                wb_dat_o <= '0;
            end
        end
    end

    // Checks
    // Most checks drop out while reset is high; the reset check does not

    // Interrupt pin matches enabled pending flags
    a_irq_follows_flags: assert property ( // [R11]
        @(posedge mclk) disable iff (reset)
        irq == |(interrupt_status & interrupt_enable))
    else $error("irq does not match enabled status");

    // Enable cleared means no interrupt at all
    a_masked_no_irq: assert property ( // [R1] [R2] [R3] [R4] [R5] [R6] [R7] [R8] [R9]
        @(posedge mclk) disable iff (reset)
        (interrupt_enable == 16'h0000) |-> !irq)
    else $error("irq raised with all sources disabled");

    // Link edge at the pin lands in bit 15 after sync
    a_link_change_latch: assert property ( // [R14]
        @(posedge mclk) disable iff (reset)
        (link_sync != link_prev) |=> interrupt_status[mqiu_pkg::BIT_LINK])
    else $error("link change not latched");

    // Every source pulse latches its bit, enabled or not
    a_source_latches: assert property ( // [R15] [R16] [R17] [R18] [R19] [R20] [R21] [R22]
        @(posedge mclk) disable iff (reset)
        (set_vec != 16'h0000) |=>
        ((interrupt_status & $past(set_vec)) == $past(set_vec)))
    else $error("source event not latched");

    // Read of status leaves all flags standing
    a_read_keeps_status: assert property ( // [R12]
        @(posedge mclk) disable iff (reset)
        (bus_req && !wb_we_i && hit_status) |=>
        (($past(interrupt_status) & ~interrupt_status) == 16'h0000))
    else $error("status bit lost on read");

    // Write-one clears exactly the written bits
    a_w1c_exact: assert property ( // [R13]
        @(posedge mclk) disable iff (reset)
        (clr_vec != 16'h0000 && set_vec == 16'h0000) |=>
        (interrupt_status == ($past(interrupt_status) & ~$past(clr_vec))))
    else $error("write-one clear wrong");

    // Event in the clear cycle survives
    a_set_beats_clear: assert property ( // [R23]
        @(posedge mclk) disable iff (reset)
        ((set_vec & clr_vec) != 16'h0000) |=>
        ((interrupt_status & $past(set_vec)) == $past(set_vec)))
    else $error("event lost against clear");

    // Enable write with both low lanes selected lands whole
    a_enable_write: assert property ( // [R1] [R9]
        @(posedge mclk) disable iff (reset)
        (bus_wr && hit_enable && wb_sel_i[1:0] == 2'h3) |=>
        (interrupt_enable == ($past(wb_dat_i[15:0]) & mqiu_pkg::IMPL_MASK)))
    else $error("enable write not stored");

    // Reserved bits never set
    a_reserved_low: assert property ( // [R10] [R22]
        @(posedge mclk) disable iff (reset)
        interrupt_enable[6:0] == 7'h00 && interrupt_status[6:0] == 7'h00)
    else $error("reserved bit set");

    // Registers come out of reset cleared; written as a forward step so
    // the first edge, before any history exists, is not judged
    a_reset_clear: assert property ( // [R10] [R22]
        @(posedge mclk)
        reset |=> (interrupt_enable == mqiu_pkg::ENABLE_RESET
            && interrupt_status == mqiu_pkg::STATUS_RESET && !irq && !wb_ack_o))
    else $error("registers not cleared by reset");

    // Ack is one cycle and answers the request of the cycle before
    a_ack_single: assert property (
        @(posedge mclk) disable iff (reset)
        bus_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle");

    // No strobe, no answer: ack only ever follows a taken request
    a_ack_needs_req: assert property (
        @(posedge mclk) disable iff (reset)
        !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without a request");

    // Status read returns the flags as they stood at the taking edge
    a_status_readback: assert property ( // [R12]
        @(posedge mclk) disable iff (reset)
        (bus_req && !wb_we_i && hit_status) |=>
        (wb_dat_o == {16'h0000, $past(interrupt_status)}))
    else $error("status read data wrong");

    // Enable read returns the gates, reserved bits as zero
    a_enable_readback: assert property ( // [R10]
        @(posedge mclk) disable iff (reset)
        (bus_req && !wb_we_i && hit_enable) |=>
        (wb_dat_o == {16'h0000, $past(interrupt_enable)}))
    else $error("enable read data wrong");

    // Unmapped reads answer zero so a stray driver sees nothing
    a_unmapped_zero: assert property (
        @(posedge mclk) disable iff (reset)
        (bus_req && !wb_we_i && !hit_enable && !hit_status) |=>
        (wb_dat_o == 32'h0000_0000))
    else $error("unmapped read not zero");

    // Gates move only on an enable write; a status access or an
    // event must never disturb them
    a_enable_steady: assert property ( // [R1] [R9]
        @(posedge mclk) disable iff (reset)
        !(bus_wr && hit_enable) |=> $stable(interrupt_enable))
    else $error("enable changed without a write");

    // A flag rises only where an event was seen the cycle before;
    // catches a clear path that sets instead of clears
    a_status_no_spurious: assert property ( // [R22]
        @(posedge mclk) disable iff (reset)
        1'b1 |=>
        ((interrupt_status & ~$past(interrupt_status) & ~$past(set_vec)) == 16'h0000))
    else $error("status bit set without an event");

    // Clearing the last enabled flag drops the pin at the next edge
    a_clear_drops_irq: assert property ( // [R11] [R13]
        @(posedge mclk) disable iff (reset)
        (clr_vec != 16'h0000 && set_vec == 16'h0000
            && ((interrupt_status & ~clr_vec & interrupt_enable) == 16'h0000)) |=> !irq)
    else $error("irq stayed up after clear");

    // Main scenarios
    c_link_irq: cover property (
        @(posedge mclk) disable iff (reset)
        (link_sync != link_prev) && interrupt_enable[mqiu_pkg::BIT_LINK] ##1 irq);

    c_set_clear_clash: cover property (
        @(posedge mclk) disable iff (reset)
        (set_vec & clr_vec) != 16'h0000);

    c_clear_drops_irq: cover property (
        @(posedge mclk) disable iff (reset)
        irq && clr_vec != 16'h0000 ##1 !irq);

    c_status_read: cover property (
        @(posedge mclk) disable iff (reset)
        bus_req && !wb_we_i && hit_status && interrupt_status != 16'h0000);

    c_masked_event: cover property (
        @(posedge mclk) disable iff (reset)
        (set_vec != 16'h0000) && ((set_vec & interrupt_enable) == 16'h0000));

endmodule // mqiu_top

// ===== tb/mqiu_src_model.sv
// Event source model: turns bench requests into event pulses and link flips
`timescale 1ns/100ps
module mqiu_src_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Requests from the bench; bit 8 flips the link
    input wire logic [8:0] fire,
    // Event levels and link pin towards the unit
    output mqiu_pkg::mqiu_events_t events,
    output logic link_up
);
    logic [8:0] fire_q; // Last request, for edge detection
    // A held request makes one pulse only, so a slow bench never counts twice
    always_ff @(posedge mclk) begin
        if (reset) begin
            fire_q <= 9'h000;
            events <= 8'h00;
            link_up <= 1'b0; // Link starts down, as the unit assumes
        end else begin
            fire_q <= fire;
            events <= fire[7:0] & ~fire_q[7:0];
            link_up <= link_up ^ (fire[8] & ~fire_q[8]);
        end
    end
endmodule // mqiu_src_model

// ===== tb/test_mac_queue_interrupt_unit.sv
// Self-checking bench for the queue interrupt unit
`timescale 1ns/100ps
module test_mac_queue_interrupt_unit;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0;
    logic [31:0] dat_o;
    logic [31:0] rdat; // Read data taken at the ack edge
    logic ack;
    logic irq;
    logic link_up;
    mqiu_pkg::mqiu_events_t events;
    logic [8:0] fire = 9'h000; // Requests to the source model
    logic [15:0] en_m = 16'h0000; // Expected enable register
    logic [15:0] st_m = 16'h0000; // Expected status register
    logic [31:0] lfsr = 32'h1d4a; // Fixed seed keeps runs repeatable
    int err_total = 0;
    int checks = 0;
    int cycles = 0;
    int b;

    // 250 MHz clock
    always #2 mclk = ~mclk;

    mqiu_top uut (.mclk(mclk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .events(events), .link_up(link_up), .irq(irq));
    mqiu_src_model src (.mclk(mclk), .reset(reset), .fire(fire), .events(events),
        .link_up(link_up));

    // Next pseudo-random word
    function automatic logic [31:0] next_rand(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // Bits covered by the selected byte lanes
    function automatic logic [15:0] lanes(input logic [3:0] s);
        return {{8{s[1]}}, {8{s[0]}}};
    endfunction

    // Compare a register value
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Compare the interrupt pin
    task automatic chk_irq(input logic exp);
        checks++;
        if (irq !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, irq, exp);
        end
    endtask

    // One classic Wishbone cycle; waits for ack, the hang guard ends a dead bus
    task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s,
        input logic [31:0] d);
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        dat <= d;
        do begin
            @(posedge mclk);
        end while (ack !== 1'b1);
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    // Write, mirrored in the expected copies
    task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
        bus(1'b1, a, s, d);
        if (a == 8'h00)
            en_m = (en_m & ~lanes(s)) | (d[15:0] & lanes(s) & mqiu_pkg::IMPL_MASK);
        if (a == 8'h08) st_m = st_m & ~(d[15:0] & lanes(s));
    endtask
    // Read and compare
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 4'hf, 32'h0);
        chk_reg(rdat, exp);
    endtask
    // Raise one source; the link needs a few edges through its synchroniser
    task automatic pulse(input int n);
        @(posedge mclk);
        fire <= 9'h001 << (n - 7);
        @(posedge mclk);
        fire <= 9'h000;
        repeat (5) @(posedge mclk);
        st_m[n] = 1'b1;
    endtask

    // Counts, verdict and end of run
    task automatic test_done();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Hang guard
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            test_done();
        end
    end

    // Main sequence
    initial begin
        repeat (6) @(posedge mclk);
        reset <= 1'b0;
        rd(8'h00, 32'h0);
        rd(8'h08, 32'h0);
        wr(8'h04, 4'h3, 32'hffff_ffff);
        rd(8'h04, 32'h0);
        wr(8'h00, 4'h3, 32'hffff_ffff);
        rd(8'h00, 32'h0000_ff80);
        $display("test reset_map done");
        // Every source in turn, random enables, lanes and clear masks
        for (int i = 0; i < 36; i++) begin
            lfsr = next_rand(lfsr);
            b = 7 + i % 9;
            wr(8'h00, {2'b00, lfsr[21:20]}, {16'h0, lfsr[15:0]});
            rd(8'h00, {16'h0, en_m});
            pulse(b);
            chk_irq(|(st_m & en_m));
            rd(8'h08, {16'h0, st_m});
            rd(8'h08, {16'h0, st_m});
            wr(8'h08, lfsr[23:20], {16'h0, lfsr[31:16]});
            rd(8'h08, {16'h0, st_m});
            chk_irq(|(st_m & en_m));
        end
        $display("test sources done");
        // Event and clear land on the same edge
        wr(8'h08, 4'h3, 32'h0000_ffff);
        @(posedge mclk);
        fire <= 9'h040;
        bus(1'b1, 8'h08, 4'h3, 32'h0000_2000);
        fire <= 9'h000;
        rd(8'h08, 32'h0000_2000);
        $display("test set_beats_clear done");
        test_done();
    end
endmodule // test_mac_queue_interrupt_unit
